// ===== strap_sync.sv
/*
  Shared constants for the memory-port strap latch, and the pin
  synchroniser that the latch instantiates.
  Assumes a single core clock at 25 MHz and an asynchronous,
  active-low chip reset; every pin input arrives unsynchronised.
*/
package strap_latch_pkg;

  // Core clock period and serial clock period, in ns
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SK_PERIOD_NS  = 320;
  // Half a serial clock period in core cycles (exact division)
  localparam int unsigned SK_HALF_CYC   = SK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  // Phase counter width and its last values
  localparam int unsigned PH_W          = 4;
  localparam logic [PH_W-1:0] PH_RISE   = PH_W'(SK_HALF_CYC - 1);
  localparam logic [PH_W-1:0] PH_LAST   = PH_W'(2 * SK_HALF_CYC - 1);

  // Cycles after release before the straps are trusted: sync depth plus margin
  localparam logic [2:0] STRAP_WAIT     = 3'h3;

  // Transfer word and bit-count widths
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned LEN_W         = 6;
  localparam logic [LEN_W-1:0] LEN_MAX  = 6'h20;

  // Synchroniser lanes and their reset levels (pull-downs, pull-up on return)
  localparam int unsigned SYNC_W        = 3;
  localparam int unsigned LANE_CLK      = 0;
  localparam int unsigned LANE_SEND     = 1;
  localparam int unsigned LANE_RET      = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h4;

  // Latch states
  typedef enum logic [1:0] {ST_SAMPLE, ST_IDLE, ST_SHIFT, ST_TAIL} latch_state_e;

endpackage

// Two-flop synchroniser for the pin inputs
module pin_sync (
  // Clock and reset
  input  wire logic                             ref_clk_in,
  input  wire logic                             arst_n_in,
  // Raw pins and synchronised levels
  input  wire logic [strap_latch_pkg::SYNC_W-1:0] pins_in,
  output logic      [strap_latch_pkg::SYNC_W-1:0] pins_out
);

  // Both stages in one state word
  typedef struct packed {
    logic [strap_latch_pkg::SYNC_W-1:0] s1;  // Metastable stage, read by s2 only
    logic [strap_latch_pkg::SYNC_W-1:0] s2;  // Settled stage
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // Shift the pins through both stages
  always_comb begin
    state_next    = state_reg;
    state_next.s1 = pins_in;
    state_next.s2 = state_reg.s1;
  end

  // Reset to the pins' idle pull levels
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= {strap_latch_pkg::SYNC_RST, strap_latch_pkg::SYNC_RST};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_out = state_reg.s2;

endmodule

// ===== mem_port_strap_latch.sv
/*
  Serial memory port with reset-time strap capture: keeps the select,
  clock and send pins released during reset, latches two straps after
  release, then runs bit transfers requested on the user port.
  Assumes the pad ring resolves each pin from its output enable, and that
  the attached memory or master respects the idle select gap.
*/
module mem_port_strap_latch (
  // Clock and reset
  input  wire logic                                ref_clk_in,
  input  wire logic                                arst_n_in,
  // Memory pins
  output logic                                     mem_select_out,
  output logic                                     mem_select_oe_out,
  input  wire logic                                mem_serial_clock_in,
  output logic                                     mem_serial_clock_out,
  output logic                                     mem_serial_clock_oe_out,
  input  wire logic                                mem_serial_send_in,
  output logic                                     mem_serial_send_out,
  output logic                                     mem_serial_send_oe_out,
  input  wire logic                                mem_serial_return_in,
  // Latched straps
  output logic                                     crossover_strap_out,
  output logic                                     led_colour_strap_out,
  // Transfer request
  input  wire logic                                xfer_start_in,
  input  wire logic [strap_latch_pkg::LEN_W-1:0]   xfer_len_in,
  input  wire logic [strap_latch_pkg::WORD_W-1:0]  xfer_data_in,
  // Transfer answer
  output logic                                     xfer_ready_out,
  output logic                                     xfer_done_out,
  output logic      [strap_latch_pkg::WORD_W-1:0]  xfer_rdata_out
);

  // Whole block state
  typedef struct packed {
    strap_latch_pkg::latch_state_e       st;       // Sequencer state
    logic [2:0]                          wait_cnt; // Strap settle count
    logic                                xover;    // Crossover strap
    logic                                led;      // LED colour strap
    logic                                drive;    // Pin drivers enabled
    logic                                sel;      // Select level
    logic                                sk;       // Serial clock level
    logic                                send;     // Send data level
    logic [strap_latch_pkg::PH_W-1:0]    phase;    // Position in clock period
    logic [strap_latch_pkg::LEN_W-1:0]   bits;     // Bits left
    logic [strap_latch_pkg::WORD_W-1:0]  tx;       // Outgoing bits, MSB first
    logic [strap_latch_pkg::WORD_W-1:0]  rx;       // Incoming bits
    logic                                ready;    // Idle and accepting
    logic                                done;     // Transfer end pulse
    logic [strap_latch_pkg::WORD_W-1:0]  rdata;    // Last word received
  } latch_s;

  latch_s state_reg;
  latch_s state_next;

  // Synchronised pin levels
  logic [strap_latch_pkg::SYNC_W-1:0] pins_sync;
  logic                               clk_pin_s;
  logic                               send_pin_s;
  logic                               ret_pin_s;

  // Every pin input crosses two flops before use
  pin_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .pins_in    ({mem_serial_return_in, mem_serial_send_in, mem_serial_clock_in}),
    .pins_out   (pins_sync)
  );

  assign clk_pin_s  = pins_sync[strap_latch_pkg::LANE_CLK];
  assign send_pin_s = pins_sync[strap_latch_pkg::LANE_SEND];
  assign ret_pin_s  = pins_sync[strap_latch_pkg::LANE_RET];

  // A length is usable when between one bit and a full word
  function automatic logic len_ok(input logic [strap_latch_pkg::LEN_W-1:0] len);
    len_ok = (len != '0) && (len <= strap_latch_pkg::LEN_MAX);
  endfunction

  // Next-state logic
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    unique case (state_reg.st)
      // Pins released; wait for the straps to settle through the syncs
      strap_latch_pkg::ST_SAMPLE: begin
        if (state_reg.wait_cnt == '0) begin
          state_next.xover = clk_pin_s;
          state_next.led   = send_pin_s;
          state_next.drive = 1'b1;
          state_next.ready = 1'b1;
          state_next.st    = strap_latch_pkg::ST_IDLE;
        end else begin
          state_next.wait_cnt = state_reg.wait_cnt - 3'h1;
        end
      end
      // Memory deselected, clock low; wait for a request
      strap_latch_pkg::ST_IDLE: begin
        state_next.sel = 1'b0;
        state_next.sk  = 1'b0;
        if (xfer_start_in && len_ok(xfer_len_in)) begin
          state_next.sel   = 1'b1;
          state_next.tx    = xfer_data_in;
          state_next.send  = xfer_data_in[strap_latch_pkg::WORD_W-1];
          state_next.bits  = xfer_len_in;
          state_next.rx    = '0;
          state_next.phase = '0;
          state_next.ready = 1'b0;
          state_next.st    = strap_latch_pkg::ST_SHIFT;
        end
      end
      // One bit per serial clock period; data set while clock is low
      strap_latch_pkg::ST_SHIFT: begin
        state_next.phase = state_reg.phase + 4'h1;
        if (state_reg.phase == strap_latch_pkg::PH_RISE) begin
          // Rising edge: memory takes our bit, we take its bit
          state_next.sk = 1'b1;
          state_next.rx = {state_reg.rx[strap_latch_pkg::WORD_W-2:0], ret_pin_s};
        end else if (state_reg.phase == strap_latch_pkg::PH_LAST) begin
          state_next.sk    = 1'b0;
          state_next.phase = '0;
          state_next.tx    = {state_reg.tx[strap_latch_pkg::WORD_W-2:0], 1'b0};
          state_next.send  = state_reg.tx[strap_latch_pkg::WORD_W-2];
          state_next.bits  = state_reg.bits - 6'h01;
          if (state_reg.bits == 6'h01) begin
            state_next.sel = 1'b0;
            state_next.st  = strap_latch_pkg::ST_TAIL;
          end
        end
      end
      // One full clock period with select low, so words stay apart
      strap_latch_pkg::ST_TAIL: begin
        state_next.phase = state_reg.phase + 4'h1;
        if (state_reg.phase == strap_latch_pkg::PH_LAST) begin
          state_next.phase = '0;
          state_next.done  = 1'b1;
          state_next.rdata = state_reg.rx;
          state_next.ready = 1'b1;
          state_next.st    = strap_latch_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Register the state; reset leaves every driver off
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg          <= '0;
      state_reg.st       <= strap_latch_pkg::ST_SAMPLE;
      state_reg.wait_cnt <= strap_latch_pkg::STRAP_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from state flops
  assign mem_select_out          = state_reg.sel;
  assign mem_select_oe_out       = state_reg.drive;
  assign mem_serial_clock_out    = state_reg.sk;
  assign mem_serial_clock_oe_out = state_reg.drive;
  assign mem_serial_send_out     = state_reg.send;
  assign mem_serial_send_oe_out  = state_reg.drive;
  assign crossover_strap_out     = state_reg.xover;
  assign led_colour_strap_out    = state_reg.led;
  assign xfer_ready_out          = state_reg.ready;
  assign xfer_done_out           = state_reg.done;
  assign xfer_rdata_out          = state_reg.rdata;

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // Select high and driven for the whole shift
  property p_sel_in_shift;
    (state_reg.st == strap_latch_pkg::ST_SHIFT) |-> mem_select_out && mem_select_oe_out;
  endproperty
  a_sel_in_shift: assert property (p_sel_in_shift)
    else $error("select not high in shift");

  // Memory deselected whenever the sequencer waits for a request
  property p_sel_low_idle;
    (state_reg.st == strap_latch_pkg::ST_IDLE) |-> !mem_select_out;
  endproperty
  a_sel_low_idle: assert property (p_sel_low_idle)
    else $error("select high in idle");

  // No pin driven until the straps are in
  property p_released_in_sample;
    (state_reg.st == strap_latch_pkg::ST_SAMPLE) |->
      !mem_select_oe_out && !mem_serial_clock_oe_out && !mem_serial_send_oe_out;
  endproperty
  a_released_in_sample: assert property (p_released_in_sample)
    else $error("pin driven early");

  // Serial clock high for exactly half a period
  property p_sk_high_width;
    $rose(mem_serial_clock_out) |-> mem_serial_clock_out [*4] ##1 !mem_serial_clock_out;
  endproperty
  a_sk_high_width: assert property (p_sk_high_width)
    else $error("clock high width wrong");

  // Send data stable while the serial clock is high
  property p_send_stable_high;
    (mem_serial_clock_out && $past(mem_serial_clock_out)) |-> $stable(mem_serial_send_out);
  endproperty
  a_send_stable_high: assert property (p_send_stable_high)
    else $error("send changed at clock high");

  // Returned bit enters the receive word at the rising edge
  property p_return_sampled;
    (state_reg.st == strap_latch_pkg::ST_SHIFT && state_reg.phase == strap_latch_pkg::PH_RISE)
      |=> (state_reg.rx[0] == $past(ret_pin_s));
  endproperty
  a_return_sampled: assert property (p_return_sampled) else $error("return bit lost");

  // Crossover strap frozen once captured
  property p_xover_frozen;
    (state_reg.st != strap_latch_pkg::ST_SAMPLE) |=> $stable(crossover_strap_out);
  endproperty
  a_xover_frozen: assert property (p_xover_frozen) else $error("crossover strap moved");

  // LED strap takes the send pin level at capture
  property p_led_capture;
    (state_reg.st == strap_latch_pkg::ST_SAMPLE && state_reg.wait_cnt == '0)
      |=> (led_colour_strap_out == $past(send_pin_s)) && mem_serial_send_oe_out;
  endproperty
  a_led_capture: assert property (p_led_capture) else $error("LED strap capture wrong");

  // Capture ends within one to six cycles of each release
  property p_capture_once;
    $rose(arst_n_in) |-> ##[1:6] (state_reg.st != strap_latch_pkg::ST_SAMPLE);
  endproperty
  a_capture_once: assert property (p_capture_once) else $error("strap capture late");

  // Done pulse only on return to idle with select low
  property p_done_idle;
    xfer_done_out |-> !mem_select_out && xfer_ready_out ##1 !xfer_done_out;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done pulse malformed");

endmodule

// ===== serial_mem_model.sv
/*
  Behavioural model of the serial memory on the far side of the port.
  Assumes the bench resolves the select and clock pins from the design's
  drive enables. The return pin has a pull-up, so it shows 1 while the
  memory is not selected.
*/
module serial_mem_model (
  // Resolved pin levels
  input  wire logic        sel_in,
  input  wire logic        clk_in,
  input  wire logic        send_in,
  // Word to return, first bit is bit 31
  input  wire logic [31:0] reply_in,
  // Return pin and collected send bits
  output logic             ret_out,
  output logic [31:0]      rx_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [4:0] idx_reg;        // Bit of reply_in now on the pin
  logic       sel_d = 1'b0;   // Select level at the last pin event
  logic       clk_d = 1'b0;   // Clock level at the last pin event

  // One process owns the frame: select rise restarts reply and collected
  // bits, a rising clock collects a send bit, a falling clock moves the
  // reply on so the next bit is valid well before the next rise
  always @(sel_in or clk_in) begin
    if (sel_in === 1'b1 && sel_d !== 1'b1) begin
      idx_reg = 5'h1F;
      rx_out  = 32'h0;
    end else if (sel_in === 1'b1 && clk_in === 1'b1 && clk_d !== 1'b1) begin
      rx_out  = {rx_out[30:0], send_in};
    end else if (sel_in === 1'b1 && clk_in === 1'b0 && clk_d === 1'b1) begin
      idx_reg = idx_reg - 5'h01;
    end
    sel_d = sel_in;
    clk_d = clk_in;
  end

  // Pull-up wins once deselected, so a stale bit never lingers
  assign ret_out = sel_in ? reply_in[idx_reg] : 1'b1;
endmodule

// ===== tb_eeprom_port_strap_latch.sv
/*
  Self-checking bench of the memory-port strap latch: strap capture for
  every strap pair, pin release in reset, refused and real transfers.
  Assumes serial_mem_model as the memory; strap resistors act as pulls.
*/
module tb_eeprom_port_strap_latch;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;      // Core clock
  logic        arst_n = 1'b0;   // Chip reset, active low
  logic        xover_pull = 1'b0; // Strap resistor on the clock pin
  logic        led_pull = 1'b0; // Strap resistor on the send pin
  logic        start = 1'b0;    // Transfer request
  logic [5:0]  len = 6'h01;     // Transfer length
  logic [31:0] data = 32'h0;    // Bits to send
  logic [31:0] reply = 32'h0;   // Memory's answer
  logic        sel, sel_oe, ck_out, ck_oe, snd_out, snd_oe;
  logic        sel_pin, ck_pin, snd_pin, ret, xover, led, ready, done;
  logic [31:0] rdata, rx;
  int          error_cnt = 0;   // Mismatches
  int          comparisons = 0; // Compares made

  // Pins resolved from drive enables and pulls
  assign sel_pin = sel_oe ? sel : 1'b0;
  assign ck_pin  = ck_oe ? ck_out : xover_pull;
  assign snd_pin = snd_oe ? snd_out : led_pull;

  // Core clock, 40 ns
  always #20 clk = ~clk;

  mem_port_strap_latch mem_port_strap_latch_i (
    .ref_clk_in(clk), .arst_n_in(arst_n),
    .mem_select_out(sel), .mem_select_oe_out(sel_oe),
    .mem_serial_clock_in(ck_pin), .mem_serial_clock_out(ck_out),
    .mem_serial_clock_oe_out(ck_oe), .mem_serial_send_in(snd_pin),
    .mem_serial_send_out(snd_out), .mem_serial_send_oe_out(snd_oe),
    .mem_serial_return_in(ret), .crossover_strap_out(xover),
    .led_colour_strap_out(led), .xfer_start_in(start), .xfer_len_in(len),
    .xfer_data_in(data), .xfer_ready_out(ready), .xfer_done_out(done),
    .xfer_rdata_out(rdata)
  );

  serial_mem_model serial_mem_model_i (
    .sel_in(sel_pin), .clk_in(ck_pin), .send_in(snd_pin),
    .reply_in(reply), .ret_out(ret), .rx_out(rx)
  );

  // Verdict and end of run
  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Exhausted wait bound ends the run
  task automatic give_up(input bit hit);
    if (hit) begin
      error_cnt++;
      report_and_stop;
    end
  endtask

  // Inputs move a fixed 2 ns after the rising edge
  task automatic tick;
    @(posedge clk);
    #2;
  endtask

  // Reset with given straps, then watch capture and hold
  task automatic strap_reset(input logic x, input logic l);
    int n;
    tick;
    arst_n = 1'b0;
    xover_pull = x;
    led_pull = l;
    // Master's single clock with select idle, while the pins are released
    repeat (2) tick;
    xover_pull = ~x;
    tick;
    xover_pull = x;
    tick;
    check(32'({sel_oe, ck_oe, snd_oe}), 32'h0);
    check(32'({xover, led, ready}), 32'h0);
    arst_n = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    give_up(n == 20);
    check(n, 32'h4);
    check(32'({ck_oe, snd_oe, sel_oe, sel}), 32'hE);
    check(32'(xover), 32'(x));
    check(32'(led), 32'(l));
    // Straps must ignore later pin levels
    xover_pull = ~x;
    led_pull = ~l;
    repeat (3) tick;
    check(32'({xover, led}), 32'({x, l}));
  endtask

  // Illegal length: nothing may start
  task automatic refuse(input logic [5:0] n_bits);
    start = 1'b1;
    len = n_bits;
    repeat (3) begin
      tick;
      check(32'({sel_pin, ready}), 32'h1);
    end
    start = 1'b0;
    // Let an edge pass so the next request never shares this time step
    tick;
  endtask

  // One transfer; enters at once when ready, so calls run back to back
  task automatic xfer(input int n_bits, input logic [31:0] d, input logic [31:0] r);
    int n;
    n = 0;
    reply = r;
    while (ready !== 1'b1 && n < 100) begin
      tick;
      n++;
    end
    give_up(n == 100);
    start = 1'b1;
    len = 6'(n_bits);
    data = d;
    tick;
    start = 1'b0;
    n = 0;
    check(32'({sel_pin, ready}), 32'h2);
    while (done !== 1'b1 && n < 400) begin
      tick;
      n++;
    end
    give_up(n == 400);
    check(n, 8 * n_bits + 8);
    check(rdata, r >> (32 - n_bits));
    check(rx, d >> (32 - n_bits));
    check(32'(sel_pin), 32'h0);
  endtask

  // Reset in mid transfer releases every pin at once
  task automatic abort_xfer;
    start = 1'b1;
    len = 6'h08;
    data = 32'hFF00_0000;
    tick;
    start = 1'b0;
    repeat (10) tick;
    arst_n = 1'b0;
    #1;
    check(32'({sel_oe, ck_oe, snd_oe}), 32'h0);
    strap_reset(1'b1, 1'b1);
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      strap_reset(i[1], i[0]);
    end
    refuse(6'h00);
    refuse(6'h21);
    xfer(1, 32'h8000_0000, 32'h0000_0000);
    xfer(32, 32'hA5C3_96E1, 32'h3C5A_0FF1);
    xfer(5, 32'h5800_0000, 32'hF000_0000);
    abort_xfer;
    xfer(3, 32'h6000_0000, 32'hA000_0000);
    report_and_stop;
  end
endmodule
